// ===== rtl/tadc_top.sv
// Control core of the temperature converter with its serial port
//
// Overview of operation
// - Trigger falling edge starts 10-bit conversion
// - Hold on trigger fall, track at end
// - Trigger low at conversion end powers down
// - Temperature result above threshold drives alert low
// - Read start (rd_wr rise while selected) releases alert
// - Shift in on rise, out on fall
// - Output released on rd_wr fall or select rise
// - Conversion uses latest written address
// - Shared pin direction follows rd_wr
// - Busy high throughout every conversion
// - Serial port answers only while selected
// - Byte upper five zero: address, else threshold
// - Compare result top eight bits with threshold
`timescale 1ns/1ps
`include "tadc_regs.svh"
module tadc_top #(
    parameter bit          SHARED_PIN  = 1'b0,
    parameter logic [15:0] CONV_CYCLES = 16'(`TADC_CONV_CYCLES)
) (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    input  wire logic       serial_clk,
    input  wire logic       conversion_trigger_n,
    input  wire logic       cs_n,
    input  wire logic       rd_wr,
    input  wire logic       data_in,
    input  wire logic       data_io_in,
    output logic            data_out,
    output logic            data_oe,
    input  wire logic [9:0] conv_data,
    output logic            busy,
    output logic            hold,
    output logic            power_down,
    output logic            over_temp_alert_n,
    output logic [2:0]      channel_sel,
    output logic [9:0]      result
);
    localparam int NS = 4;          // conv trigger, select, rd_wr, byte toggle

    tadc_link_if lnk ();

    logic [NS-1:0] raw;
    logic [NS-1:0] sync1;
    logic [NS-1:0] sync2;
    logic [NS-1:0] sync3;
    logic [NS-1:0] lvl;
    logic [NS-1:0] next_lvl;
    logic [NS-1:0] rise;
    logic [NS-1:0] fall;

    tadc_pkg::tadc_state_t state;
    tadc_pkg::tadc_state_t next_state;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic [7:0]  thr;
    logic [7:0]  next_thr;
    logic [2:0]  addr;
    logic [2:0]  next_addr;
    logic        next_busy;
    logic        next_hold;
    logic        next_pd;
    logic        next_alert_n;
    logic [2:0]  next_chan;
    logic [9:0]  next_result;
    logic        next_oe;

    // Byte routing decode, upper five bits select the target
    function automatic logic tadc_is_addr(input logic [7:0] b);
        tadc_is_addr = (b[`TADC_SEL_HI_MSB:`TADC_SEL_HI_LSB] == 5'h00);
    endfunction : tadc_is_addr

    tadc_link u_link (
        .serial_clk (serial_clk),
        .rst_b      (rst_b),
        .cs_n       (cs_n),
        .rd_wr      (rd_wr),
        .data_in    (SHARED_PIN ? data_io_in : data_in),
        .lnk        (lnk.link)
    );

    // Result is quasi-static: it changes only at conversion end, so reads
    // must not overlap a conversion end (host waits for busy to fall).
    assign lnk.tx_word = result;
    assign data_out    = lnk.tx_bit;
    assign raw         = {lnk.rx_tog, rd_wr, cs_n, conversion_trigger_n};

    // ------------------------------------------------------------
    // Synchronisers: three stages, level accepted when stages 2/3 agree
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_sync
            always_comb begin
                next_lvl[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : lvl[gi];
                rise[gi]     = next_lvl[gi] & ~lvl[gi];
                fall[gi]     = ~next_lvl[gi] & lvl[gi];
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            // Idle levels avoid a false toggle or rd_wr edge after reset
            sync1 <= `TADC_SYNC_RST;
            sync2 <= `TADC_SYNC_RST;
            sync3 <= `TADC_SYNC_RST;
            lvl   <= `TADC_SYNC_RST;
        end else if (clk_en) begin
            sync1 <= raw;
            sync2 <= sync1;
            sync3 <= sync2;
            lvl   <= next_lvl;
        end
    end

    // ------------------------------------------------------------
    // Conversion control and registers
    // ------------------------------------------------------------
    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_thr     = thr;
        next_addr    = addr;
        next_busy    = busy;
        next_hold    = hold;
        next_pd      = power_down;
        next_alert_n = over_temp_alert_n;
        next_chan    = channel_sel;
        next_result  = result;

        if (rise[3] || fall[3]) begin
            if (tadc_is_addr(lnk.rx_byte)) begin
                next_addr = lnk.rx_byte[2:0];
            end else begin
                next_thr = lnk.rx_byte;
            end
        end

        if (rise[2] && !lvl[1]) begin
            next_alert_n = 1'b1;
        end

        case (state)
            tadc_pkg::TADC_IDLE: begin
                if (fall[0]) begin
                    next_state = tadc_pkg::TADC_CONV;
                    next_cnt   = CONV_CYCLES - 16'h1;
                    next_busy  = 1'b1;
                    next_hold  = 1'b1;
                    next_pd    = 1'b0;
                    next_chan  = addr;
                end
            end
            tadc_pkg::TADC_CONV: begin
                if (cnt == 16'h0) begin
                    next_state  = tadc_pkg::TADC_IDLE;
                    next_busy   = 1'b0;
                    next_hold   = 1'b0;
                    next_result = conv_data;
                    next_pd     = ~next_lvl[0];
                    if (channel_sel == `TADC_CH_TEMP) begin
                        if (conv_data[`TADC_THR_MSB:`TADC_THR_LSB] > thr) begin
                            next_alert_n = 1'b0;    // Set wins over read release
                        end else begin
                            next_alert_n = 1'b1;
                        end
                    end
                end else begin
                    next_cnt = cnt - 16'h1;
                end
            end
            default: begin
                next_state = tadc_pkg::TADC_IDLE;
                next_busy  = 1'b0;
                next_hold  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state             <= tadc_pkg::TADC_IDLE;
            cnt               <= 16'h0;
            thr               <= `TADC_THR_RST;
            addr              <= `TADC_ADDR_RST;
            busy              <= 1'b0;
            hold              <= 1'b0;
            power_down        <= 1'b0;
            over_temp_alert_n <= 1'b1;
            channel_sel       <= `TADC_ADDR_RST;
            result            <= 10'h000;
        end else if (clk_en) begin
            state             <= next_state;
            cnt               <= next_cnt;
            thr               <= next_thr;
            addr              <= next_addr;
            busy              <= next_busy;
            hold              <= next_hold;
            power_down        <= next_pd;
            over_temp_alert_n <= next_alert_n;
            channel_sel       <= next_chan;
            result            <= next_result;
        end
    end

    // ------------------------------------------------------------
    // Output enable of the data pin
    // ------------------------------------------------------------
    // release on rd_wr fall or select rise
    always_comb begin
        next_oe = next_lvl[2] & ~next_lvl[1];
        if (fall[2] || rise[1]) begin
            next_oe = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            data_oe <= 1'b0;
        end else if (clk_en) begin
            data_oe <= next_oe;
        end
    end
endmodule : tadc_top

// ===== rtl/tadc_regs.svh
// Constants of the temperature converter control block
`ifndef TADC_REGS_SVH
`define TADC_REGS_SVH

`define TADC_RES_W          10
`define TADC_CTRL_W         8
`define TADC_ADDR_W         3
`define TADC_ADDR_RST       3'h0
`define TADC_THR_RST        8'h99
// Sync chain idle levels: byte toggle and rd_wr low, select and trigger high
`define TADC_SYNC_RST       4'h3
`define TADC_CH_TEMP        3'h0
`define TADC_SEL_HI_MSB     7
`define TADC_SEL_HI_LSB     3
`define TADC_THR_MSB        9
`define TADC_THR_LSB        2
`define TADC_CLK_NS         10
`define TADC_CONV_TIME_NS   1000
`define TADC_CONV_CYCLES    ((`TADC_CONV_TIME_NS + `TADC_CLK_NS - 1) / `TADC_CLK_NS)
`define TADC_RX_BITS        4'h8
`define TADC_TX_BITS        4'ha

`endif

// ===== rtl/tadc_pkg.sv
// Types shared by the converter control modules
package tadc_pkg;
    typedef enum logic [1:0] {
        TADC_IDLE = 2'b01,
        TADC_CONV = 2'b10
    } tadc_state_t;
endpackage : tadc_pkg

// ===== rtl/tadc_link_if.sv
// Carrier between the control core and the serial link logic
`timescale 1ns/1ps
interface tadc_link_if;
    logic [7:0] rx_byte;    // Last complete written byte
    logic       rx_tog;     // Flips once per written byte
    logic [9:0] tx_word;    // Result presented to reads
    logic       tx_bit;     // Bit on the data output

    modport core (input rx_byte, input rx_tog, output tx_word, input tx_bit);
    modport link (output rx_byte, output rx_tog, input tx_word, output tx_bit);
endinterface : tadc_link_if

// ===== rtl/tadc_link.sv
// Serial link logic clocked by the host serial clock
`timescale 1ns/1ps
`include "tadc_regs.svh"
module tadc_link (
    input  wire logic  serial_clk,
    input  wire logic  rst_b,
    input  wire logic  cs_n,
    input  wire logic  rd_wr,
    input  wire logic  data_in,
    tadc_link_if.link  lnk
);
    logic [7:0] rx_sh;
    logic [7:0] next_rx_sh;
    logic [3:0] rx_cnt;
    logic [3:0] next_rx_cnt;
    logic [7:0] next_rx_byte;
    logic       next_rx_tog;
    logic [3:0] tx_cnt;
    logic [3:0] next_tx_cnt;
    logic       next_tx_bit;

    // ------------------------------------------------------------
    // Write side, rising edges
    // ------------------------------------------------------------
    // shift in on rise
    always_comb begin
        next_rx_sh   = rx_sh;
        next_rx_cnt  = rx_cnt;
        next_rx_byte = lnk.rx_byte;
        next_rx_tog  = lnk.rx_tog;
        if (!cs_n && !rd_wr) begin
            next_rx_sh = {rx_sh[6:0], data_in};
            if (rx_cnt == `TADC_RX_BITS - 4'h1) begin
                next_rx_cnt  = 4'h0;
                next_rx_byte = {rx_sh[6:0], data_in};
                next_rx_tog  = ~lnk.rx_tog;     // One event per byte
            end else begin
                next_rx_cnt = rx_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge serial_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_sh       <= 8'h00;
            rx_cnt      <= 4'h0;
            lnk.rx_byte <= 8'h00;
            lnk.rx_tog  <= 1'b0;
        end else begin
            rx_sh       <= next_rx_sh;
            rx_cnt      <= next_rx_cnt;
            lnk.rx_byte <= next_rx_byte;
            lnk.rx_tog  <= next_rx_tog;
        end
    end

    // ------------------------------------------------------------
    // Read side, falling edges
    // ------------------------------------------------------------
    // MSB first, ten bits
    always_comb begin
        next_tx_cnt = tx_cnt;
        next_tx_bit = lnk.tx_bit;
        if (!cs_n && rd_wr) begin
            next_tx_bit = lnk.tx_word[4'h9 - tx_cnt];
            next_tx_cnt = (tx_cnt == `TADC_TX_BITS - 4'h1) ? 4'h0 : tx_cnt + 4'h1;
        end
    end

    // Counters wrap by frame length since the clock stops between frames
    always_ff @(negedge serial_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_cnt     <= 4'h0;
            lnk.tx_bit <= 1'b0;
        end else begin
            tx_cnt     <= next_tx_cnt;
            lnk.tx_bit <= next_tx_bit;
        end
    end
endmodule : tadc_link

// ===== tb/tadc_top_props.sv
// Concurrent checks on the converter control ports
`timescale 1ns/1ps
module tadc_top_props #(
    parameter logic [15:0] CONV_CYCLES = 16'h0064
) (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       conversion_trigger_n,
    input  wire logic       cs_n,
    input  wire logic       rd_wr,
    input  wire logic       data_oe,
    input  wire logic       busy,
    input  wire logic       hold,
    input  wire logic       over_temp_alert_n,
    input  wire logic [2:0] channel_sel,
    input  wire logic [9:0] result
);
    logic [15:0] run;
    // Busy length counter; clears between conversions
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) run <= 16'h0000;
        else run <= busy ? run + 16'h0001 : 16'h0000;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_hold; hold == busy; endproperty
    a_hold: assert property (p_hold) else $error("hold differs from busy");
    property p_len; $fell(busy) |-> run == CONV_CYCLES; endproperty
    a_len: assert property (p_len) else $error("busy length wrong");
    property p_start; $rose(busy) |-> !conversion_trigger_n && $past(conversion_trigger_n, 6);
    endproperty
    a_start: assert property (p_start) else $error("start without trigger fall");
    property p_chan; busy && $past(busy) |-> $stable(channel_sel) && $stable(result); endproperty
    a_chan: assert property (p_chan) else $error("channel or result moved");
    property p_res; $changed(result) |-> $fell(busy); endproperty
    a_res: assert property (p_res) else $error("result changed off end");
    property p_alo; $fell(over_temp_alert_n) |-> $fell(busy) && channel_sel == 3'h0; endproperty
    a_alo: assert property (p_alo) else $error("alert set wrongly");
    property p_ahi; $rose(over_temp_alert_n) |-> $fell(busy) || (rd_wr && !cs_n); endproperty
    a_ahi: assert property (p_ahi) else $error("alert released wrongly");
    property p_oecs; cs_n [*6] |-> !data_oe; endproperty
    a_oecs: assert property (p_oecs) else $error("output on while deselected");
    property p_oerw; !rd_wr [*6] |-> !data_oe; endproperty
    a_oerw: assert property (p_oerw) else $error("output on during write");
endmodule : tadc_top_props

bind tadc_top tadc_top_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (
    .clock(clock), .rst_b(rst_b), .conversion_trigger_n(conversion_trigger_n),
    .cs_n(cs_n), .rd_wr(rd_wr), .data_oe(data_oe), .busy(busy), .hold(hold),
    .over_temp_alert_n(over_temp_alert_n), .channel_sel(channel_sel), .result(result));

// ===== tb/tadc_host.sv
// Host serial master model driving the converter serial port
`timescale 1ns/1ps
module tadc_host (
    output logic      serial_clk,
    output logic      cs_n,
    output logic      rd_wr,
    output logic      data_in,
    input  wire logic data_out,
    input  wire logic data_oe
);
    localparam realtime HALF = 7.5;
    // Serial clock stands low outside frames
    initial begin
        serial_clk = 1'b0;
        cs_n = 1'b1;
        rd_wr = 1'b0;
        data_in = 1'b0;
    end
    // Write a byte MSB first; sel low keeps the part deselected
    task automatic put_byte(input logic [7:0] b, input logic sel);
        // Stay off the core clock edges
        #3;
        rd_wr = 1'b0;
        cs_n = !sel;
        #40;
        for (int i = 7; i >= 0; i--) begin
            // data settles before the rising edge
            data_in = b[i];
            #HALF serial_clk = 1'b1;
            #HALF serial_clk = 1'b0;
        end
        // Released line flips so a stale bit is never read as valid
        data_in = ~data_in;
        #60 cs_n = 1'b1;
        #60;
    endtask : put_byte
    // Read ten bits; each is taken just before the next rising edge
    task automatic get_word(output logic [9:0] w, output logic [1:0] oe);
        #3 cs_n = 1'b0;
        #20 rd_wr = 1'b1;
        #60 oe[1] = data_oe;
        for (int i = 9; i >= 0; i--) begin
            serial_clk = 1'b1;
            #HALF serial_clk = 1'b0;
            #HALF w[i] = data_out;
        end
        rd_wr = 1'b0;
        // output must be off before select rises
        #60 oe[0] = data_oe;
        cs_n = 1'b1;
        #60;
    endtask : get_word
endmodule : tadc_host

// ===== tb/temp_adc_serial_control_tb.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
module temp_adc_serial_control_tb;
    logic       clock = 1'b0;
    logic       rst_b = 1'b0;
    logic       conversion_trigger_n = 1'b1;
    logic [9:0] conv_data = 10'h000;
    logic [9:0] word;
    logic [1:0] oe;
    logic       clk_en = 1'b1;
    wire logic  sh_pin, sh_out, sh_oe;
    wire logic [2:0] sh_chan;
    wire logic  serial_clk, cs_n, rd_wr, data_in, data_out, data_oe;
    wire logic  busy, hold, power_down, over_temp_alert_n;
    wire logic [2:0] channel_sel;
    wire logic [9:0] result;
    int         errors = 0;
    int         comparisons = 0;
    always #5 clock = ~clock;
    tadc_host host (.serial_clk(serial_clk), .cs_n(cs_n), .rd_wr(rd_wr),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
    // Short conversion keeps the run brief
    tadc_top #(.SHARED_PIN(1'b0), .CONV_CYCLES(16'h0008)) uut (.clock(clock),
        .rst_b(rst_b), .clk_en(clk_en), .serial_clk(serial_clk),
        .conversion_trigger_n(conversion_trigger_n), .cs_n(cs_n), .rd_wr(rd_wr),
        .data_in(data_in), .data_io_in(data_oe ? data_out : data_in),
        .data_out(data_out), .data_oe(data_oe), .conv_data(conv_data), .busy(busy),
        .hold(hold), .power_down(power_down), .over_temp_alert_n(over_temp_alert_n),
        .channel_sel(channel_sel), .result(result));
    // Shared-pin variant; its separate input is inverted so a wrong source shows
    assign sh_pin = sh_oe ? sh_out : data_in;
    tadc_top #(.SHARED_PIN(1'b1), .CONV_CYCLES(16'h0008)) uut_shared (.clock(clock),
        .rst_b(rst_b), .clk_en(clk_en), .serial_clk(serial_clk),
        .conversion_trigger_n(conversion_trigger_n), .cs_n(cs_n), .rd_wr(rd_wr),
        .data_in(~data_in), .data_io_in(sh_pin), .data_out(sh_out), .data_oe(sh_oe),
        .conv_data(conv_data), .busy(), .hold(), .power_down(), .over_temp_alert_n(),
        .channel_sel(sh_chan), .result());
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One conversion; low_end keeps the trigger low past the end
    task automatic convert(input logic [9:0] code, input logic low_end);
        int n;
        @(posedge clock);
        conv_data <= code;
        conversion_trigger_n <= 1'b0;
        for (n = 0; n < 20 && busy !== 1'b1; n++) @(negedge clock);
        chk({8'h00, busy, hold}, 10'h003);
        // Set the end level early: the synchroniser needs about four cycles
        repeat (1) @(posedge clock);
        conversion_trigger_n <= !low_end;
        for (n = 0; n < 20 && busy !== 1'b0; n++) @(negedge clock);
        chk({8'h00, hold, power_down}, {9'h000, low_end});
        chk(result, code);
        @(posedge clock);
        conversion_trigger_n <= 1'b1;
        repeat (8) @(posedge clock);
    endtask : convert
    task automatic read_chk(input logic [9:0] exp);
        host.get_word(word, oe);
        chk(word, exp);
        chk({8'h00, oe}, 10'h002);
    endtask : read_chk
    // Clock enable low freezes the core, so a trigger fall is not seen
    task automatic t_freeze;
        @(posedge clock);
        clk_en <= 1'b0;
        conversion_trigger_n <= 1'b0;
        repeat (12) @(negedge clock);
        chk({9'h000, busy}, 10'h000);
        @(posedge clock);
        clk_en <= 1'b1;
        conversion_trigger_n <= 1'b1;
        repeat (8) @(posedge clock);
        chk({9'h000, busy}, 10'h000);
        $display("freeze test done");
    endtask : t_freeze
    task automatic t_alert;
        host.put_byte(8'h80, 1'b1);
        convert(10'h204, 1'b0);
        chk({9'h000, over_temp_alert_n}, 10'h000);
        read_chk(10'h204);
        chk({9'h000, over_temp_alert_n}, 10'h001);
        // Top eight bits equal to the threshold are not above it
        convert(10'h203, 1'b0);
        chk({9'h000, over_temp_alert_n}, 10'h001);
        $display("alert test done");
    endtask : t_alert
    task automatic t_addr;
        host.put_byte(8'h05, 1'b1);
        host.put_byte(8'h03, 1'b0);
        convert(10'h3ff, 1'b1);
        chk({7'h00, channel_sel}, 10'h005);
        chk({7'h00, sh_chan}, 10'h005);
        chk({9'h000, over_temp_alert_n}, 10'h001);
        host.put_byte(8'h00, 1'b1);
        convert(10'h155, 1'b0);
        chk({7'h00, channel_sel}, 10'h000);
        chk({7'h00, sh_chan}, 10'h000);
        read_chk(10'h155);
        $display("address test done");
    endtask : t_addr
    task automatic results;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    initial begin
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        @(negedge clock);
        chk({5'h00, busy, hold, power_down, over_temp_alert_n, data_oe}, 10'h002);
        t_freeze();
        t_alert();
        t_addr();
        results();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #100000;
        errors++;
        results();
    end
endmodule : temp_adc_serial_control_tb
